/* File: src/ewp_regs.svh */
// Purpose: Constants of the write-protect and status logic of a serial EEPROM.
// Assumes: System clock of 40 MHz; serial link clocked by the host.
// Notes: Non-volatile bits take a reset value here, as no array model exists.
// Functional notes
// - No internal write unless latch was set.
// - Set command sets latch, clear command clears.
// - Latch cleared at power-up and after writes.
// - Status read works anytime, even while busy.
// - Status bits: enable, three spare, guards, latch, busy.
// - Busy flag reads one exactly during writes.
// - Latch flag mirrors latch, unaffected by protection.
// - Guard bits change only through status write.
// - Guard pair selects none, quarter, half, all.
// - Hardware protection needs pin low and enable.
// - Hardware protection blocks only status bit writes.
// - Permission matrix of latch, guards and protection.
// - Write starts only on exact deselect boundary.
// - Array access during write cycle is ignored.
// - Powers up idle, latch clear, output released.
// - Status write is sixteen bits, output stays released.
// - Set and clear command codes, one byte.
// - Most significant bit first; status command codes.
// - Latch sets only after deselect following command.
// - Pin falling mid-write leaves that write intact.
`ifndef EWP_REGS_SVH
`define EWP_REGS_SVH

`define EWP_CLK_HZ         40000000
`define EWP_WRITE_TIME_NS  5000000
`define EWP_WRITE_CYCLES   ((`EWP_WRITE_TIME_NS * (`EWP_CLK_HZ / 1000000)) / 1000)

`define EWP_OP_ARRAY_WRITE 8'h02
`define EWP_OP_LATCH_CLR   8'h04
`define EWP_OP_LATCH_SET   8'h06
`define EWP_OP_SR_READ     8'h05
`define EWP_OP_SR_WRITE    8'h01

`define EWP_BYTE_BITS      12'h008
`define EWP_SR_WRITE_BITS  12'h010
`define EWP_ADDR_END_BITS  12'h018
`define EWP_ARRAY_MIN_BITS 12'h020
`define EWP_BITS_MAX       12'hfff

`define EWP_SR_PPE         7
`define EWP_SR_BG_HI       3
`define EWP_SR_BG_LO       2
`define EWP_SR_LATCH       1
`define EWP_SR_BUSY        0
`define EWP_NV_RESET       3'h0

`define EWP_GUARD_NONE     2'h0
`define EWP_GUARD_QUARTER  2'h1
`define EWP_GUARD_HALF     2'h2
`define EWP_QUARTER_BASE   12'hc00
`define EWP_HALF_BASE      12'h800

`endif

/* File: src/ewp_pkg.sv */
// Purpose: Types shared by the serial front end and the protection core.
// Assumes: Constants come from ewp_regs.svh.
// Notes: The frame record is quasi-static once chip select has risen.
package ewp_pkg;

	typedef struct packed {
		logic [7:0]  opcode;
		logic [7:0]  data;
		logic [11:0] addr;
		logic [11:0] bits;
	} ewp_frame_t;

	typedef enum logic {
		ewp_st_idle,
		ewp_st_busy
	} ewp_state_t;

	typedef enum logic [1:0] {
		ewp_wk_none,
		ewp_wk_status,
		ewp_wk_array
	} ewp_kind_t;

endpackage : ewp_pkg

/* File: src/ewp_serial_port.sv */
// Purpose: Serial front end on the host clock: shifts in frames, drives status out.
// Assumes: Host clock stands still outside frames; chip select ends every frame.
// Notes: Frame fields hold after deselect so the core can read them later.
`timescale 1ns/100ps
`include "ewp_regs.svh"
module ewp_serial_port
	import ewp_pkg::*;
(
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	input  wire logic [7:0]  status_val,
	output ewp_frame_t       frame_rec,
	output logic             so,
	output logic             so_oe_n
);

	logic        armed_r;
	logic [11:0] sh_r;
	logic [11:0] sh_nxt;
	ewp_frame_t  fr_r;
	ewp_frame_t  fr_nxt;
	logic [7:0]  st_m_r;
	logic [7:0]  st_s_r;
	logic        so_r;
	logic        so_nxt;
	logic        oe_n_r;
	logic        oe_n_nxt;

	function automatic logic [11:0] sat_inc(input logic [11:0] v);
		sat_inc = (v == `EWP_BITS_MAX) ? v : v + 12'h001;
	endfunction : sat_inc

	always_comb begin
		sh_nxt = {sh_r[10:0], si};
		fr_nxt = fr_r;
		fr_nxt.bits = armed_r ? 12'h001 : sat_inc(fr_r.bits);
		if (fr_nxt.bits == `EWP_BYTE_BITS) begin
			fr_nxt.opcode = sh_nxt[7:0];
		end
		if (fr_nxt.bits == `EWP_SR_WRITE_BITS) begin
			fr_nxt.data = sh_nxt[7:0];
		end
		if (fr_nxt.bits == `EWP_ADDR_END_BITS) begin
			fr_nxt.addr = sh_nxt;
		end
	end

	// Armed by deselect so the first edge of a frame restarts the count.
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			armed_r <= 1'b1;
		end else begin
			armed_r <= 1'b0;
		end
	end

	always_ff @(posedge sck) begin
		sh_r   <= sh_nxt;
		fr_r   <= fr_nxt;
		st_m_r <= status_val;
		st_s_r <= st_m_r;
	end

	// Only a status read ever drives the output; status writes leave it released.
	always_comb begin
		so_nxt   = 1'b0;
		oe_n_nxt = 1'b1;
		if (fr_r.opcode == `EWP_OP_SR_READ && fr_r.bits >= `EWP_BYTE_BITS) begin
			so_nxt   = st_s_r[~fr_r.bits[2:0]];
			oe_n_nxt = 1'b0;
		end
	end

	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so_r   <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			so_r   <= so_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign frame_rec = fr_r;
	assign so        = so_r;
	assign so_oe_n = oe_n_r;

	only_status_drives_a : assert property (@(negedge sck) disable iff (cs_n)
		!oe_n_r |-> fr_r.opcode == `EWP_OP_SR_READ && fr_r.bits >= `EWP_BYTE_BITS)
		else $error("Serial output driven outside a status read.");

endmodule : ewp_serial_port

/* File: src/ewp_protect_top.sv */
// Purpose: Write enable latch, status register, block guards and busy timing.
// Assumes: Host keeps chip select high for at least four system clocks.
// Notes: Frame fields cross on the synchronised rise of chip select.
`timescale 1ns/100ps
`include "ewp_regs.svh"
module ewp_protect_top
	import ewp_pkg::*;
#(
	parameter int WRITE_CYCLES = `EWP_WRITE_CYCLES
)(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	input  wire logic        protect_n,
	output logic             so,
	output logic             so_oe_n,
	output logic [7:0]       status_q,
	output logic             write_busy
);

	localparam int TW = $clog2(WRITE_CYCLES + 1);
	localparam logic [2:0] NV_RST = `EWP_NV_RESET;

	ewp_frame_t  fr;
	logic        cs_m_r;
	logic        cs_s_r;
	logic        cs_d_r;
	logic        pr_m_r;
	logic        pr_s_r;
	logic        frame_end;
	logic        hw_prot;
	logic        array_ok;

	ewp_state_t  state_r;
	ewp_state_t  state_nxt;
	logic [TW-1:0] timer_r;
	logic [TW-1:0] timer_nxt;
	logic        latch_r;
	logic        latch_nxt;
	ewp_kind_t   kind_r;
	ewp_kind_t   kind_nxt;
	logic [2:0]  pend_r;
	logic [2:0]  pend_nxt;
	logic        ppe_r;
	logic        ppe_nxt;
	logic [1:0]  bg_r;
	logic [1:0]  bg_nxt;
	logic [7:0]  status_r;
	logic [7:0]  status_nxt;
	logic        busy_q_r;

	// Guarded when the start address falls in a protected quarter; a page never
	// straddles two quarters, so checking the start address is enough.
	function automatic logic guarded(input logic [1:0] bg, input logic [11:0] addr);
		case (bg)
			`EWP_GUARD_NONE:    guarded = 1'b0;
			`EWP_GUARD_QUARTER: guarded = addr >= `EWP_QUARTER_BASE;
			`EWP_GUARD_HALF:    guarded = addr >= `EWP_HALF_BASE;
			default:            guarded = 1'b1;
		endcase
	endfunction : guarded

	ewp_serial_port u_port (
		.sck      (sck),
		.cs_n     (cs_n),
		.si       (si),
		.status_val (status_r),
		.frame_rec  (fr),
		.so       (so),
		.so_oe_n  (so_oe_n)
	);

	// Chip select and the protect pin are foreign to this clock.
	always_ff @(posedge clock) begin
		if (rst) begin
			cs_m_r <= 1'b1;
			cs_s_r <= 1'b1;
			cs_d_r <= 1'b1;
			pr_m_r <= 1'b1;
			pr_s_r <= 1'b1;
		end else begin
			cs_m_r <= cs_n;
			cs_s_r <= cs_m_r;
			cs_d_r <= cs_s_r;
			pr_m_r <= protect_n;
			pr_s_r <= pr_m_r;
		end
	end

	// The frame record settled on the host clock before chip select rose.
	assign frame_end = cs_s_r & ~cs_d_r;
	assign hw_prot   = ~pr_s_r & ppe_r;
	assign array_ok  = fr.bits >= `EWP_ARRAY_MIN_BITS && fr.bits[2:0] == 3'h0;

	always_comb begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		latch_nxt = latch_r;
		kind_nxt  = kind_r;
		pend_nxt  = pend_r;
		ppe_nxt   = ppe_r;
		bg_nxt    = bg_r;
		case (state_r)
			ewp_st_idle: begin
				if (frame_end) begin
					case (fr.opcode)
						`EWP_OP_LATCH_SET: begin
							if (fr.bits == `EWP_BYTE_BITS) begin
								latch_nxt = 1'b1;
							end
						end
						`EWP_OP_LATCH_CLR: begin
							if (fr.bits == `EWP_BYTE_BITS) begin
								latch_nxt = 1'b0;
							end
						end
						`EWP_OP_SR_WRITE: begin
							// Protection is sampled once here, so a later pin change
							// cannot disturb a cycle already under way.
							if (fr.bits == `EWP_SR_WRITE_BITS && latch_r && !hw_prot) begin
								state_nxt = ewp_st_busy;
								timer_nxt = '0;
								kind_nxt  = ewp_wk_status;
								pend_nxt  = {fr.data[`EWP_SR_PPE],
									fr.data[`EWP_SR_BG_HI], fr.data[`EWP_SR_BG_LO]};
							end
						end
						`EWP_OP_ARRAY_WRITE: begin
							if (array_ok && latch_r && !guarded(bg_r, fr.addr)) begin
								state_nxt = ewp_st_busy;
								timer_nxt = '0;
								kind_nxt  = ewp_wk_array;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ewp_st_busy: begin
				// Every frame that ends during the cycle is dropped; only status reads,
				// served by the front end, see anything.
				if (timer_r == TW'(WRITE_CYCLES - 1)) begin
					state_nxt = ewp_st_idle;
					latch_nxt = 1'b0;
					if (kind_r == ewp_wk_status) begin
						{ppe_nxt, bg_nxt} = pend_r;
					end
					kind_nxt = ewp_wk_none;
				end else begin
					timer_nxt = timer_r + TW'(1);
				end
			end
			default: begin
				state_nxt = ewp_st_idle;
			end
		endcase
		status_nxt                = 8'h00;
		status_nxt[`EWP_SR_PPE]   = ppe_nxt;
		status_nxt[`EWP_SR_BG_HI] = bg_nxt[1];
		status_nxt[`EWP_SR_BG_LO] = bg_nxt[0];
		status_nxt[`EWP_SR_LATCH] = latch_nxt;
		status_nxt[`EWP_SR_BUSY]  = state_nxt == ewp_st_busy;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r  <= ewp_st_idle;
			timer_r  <= '0;
			latch_r  <= 1'b0;
			kind_r   <= ewp_wk_none;
			pend_r   <= 3'h0;
			ppe_r    <= NV_RST[2];
			bg_r     <= NV_RST[1:0];
			status_r <= {NV_RST[2], 3'h0, NV_RST[1:0], 2'h0};
			busy_q_r <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			timer_r  <= timer_nxt;
			latch_r  <= latch_nxt;
			kind_r   <= kind_nxt;
			pend_r   <= pend_nxt;
			ppe_r    <= ppe_nxt;
			bg_r     <= bg_nxt;
			status_r <= status_nxt;
			busy_q_r <= state_nxt == ewp_st_busy;
		end
	end

	assign status_q   = status_r;
	assign write_busy = busy_q_r;

	no_unlatched_write_a : assert property (@(posedge clock) disable iff (rst)
		$rose(state_r == ewp_st_busy) |-> $past(latch_r))
		else $error("Write cycle started with the latch clear.");

	latch_set_cmd_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_LATCH_SET
		&& fr.bits == `EWP_BYTE_BITS |=> latch_r ##1 status_r[`EWP_SR_LATCH])
		else $error("Set command did not set the latch.");

	latch_after_write_a : assert property (@(posedge clock) disable iff (rst)
		$fell(state_r == ewp_st_busy) |-> !latch_r && !status_r[`EWP_SR_LATCH])
		else $error("Latch still set after a write cycle.");

	status_layout_a : assert property (@(posedge clock) disable iff (rst)
		##1 status_r == {$past(ppe_nxt), 3'h0, $past(bg_nxt), $past(latch_nxt),
		$past(state_nxt == ewp_st_busy)})
		else $error("Status register layout is wrong.");

	busy_length_a : assert property (@(posedge clock) disable iff (rst)
		$fell(state_r == ewp_st_busy) |-> $past(timer_r) == TW'(WRITE_CYCLES - 1))
		else $error("Write cycle length is wrong.");

	busy_flag_a : assert property (@(posedge clock) disable iff (rst)
		write_busy == (state_r == ewp_st_busy) && status_r[`EWP_SR_BUSY] == write_busy)
		else $error("Busy flag does not follow the write cycle.");

	guard_source_a : assert property (@(posedge clock) disable iff (rst)
		!$stable({ppe_r, bg_r}) |-> $past(kind_r) == ewp_wk_status && $fell(state_r == ewp_st_busy))
		else $error("Non-volatile bits changed without a status write.");

	hw_protect_block_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_SR_WRITE && hw_prot
		|=> state_r == ewp_st_idle ##1 $stable({ppe_r, bg_r}))
		else $error("Status write accepted under hardware protection.");

	guarded_block_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_ARRAY_WRITE
		&& guarded(bg_r, fr.addr) |=> state_r == ewp_st_idle)
		else $error("Write accepted into a guarded block.");

	busy_ignore_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_busy && timer_r != TW'(WRITE_CYCLES - 1) && frame_end
		|=> state_r == ewp_st_busy && $stable(latch_r))
		else $error("Frame acted on during a write cycle.");

	latch_bits_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.bits != `EWP_BYTE_BITS
		&& (fr.opcode == `EWP_OP_LATCH_SET || fr.opcode == `EWP_OP_LATCH_CLR)
		|=> $stable(latch_r))
		else $error("Latch changed on a frame of the wrong length.");

	latch_clr_cmd_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_LATCH_CLR
		&& fr.bits == `EWP_BYTE_BITS |=> !latch_r && !status_r[`EWP_SR_LATCH])
		else $error("Clear command did not clear the latch.");

	latch_mirror_a : assert property (@(posedge clock) disable iff (rst)
		status_r[`EWP_SR_LATCH] == latch_r)
		else $error("Latch flag does not follow the latch.");

	power_up_state_a : assert property (@(posedge clock)
		rst |=> state_r == ewp_st_idle && !latch_r && !write_busy
		&& status_r == {NV_RST[2], 3'h0, NV_RST[1:0], 2'h0})
		else $error("State after reset is wrong.");

	unlatched_refuse_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && !latch_r |=> state_r == ewp_st_idle)
		else $error("Write cycle started without the latch.");

	status_len_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_SR_WRITE
		&& fr.bits != `EWP_SR_WRITE_BITS |=> state_r == ewp_st_idle)
		else $error("Status write started on a frame of the wrong length.");

	array_len_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_ARRAY_WRITE
		&& (fr.bits < `EWP_ARRAY_MIN_BITS || fr.bits[2:0] != 3'h0) |=> state_r == ewp_st_idle)
		else $error("Array write started on a frame of the wrong length.");

	status_accept_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_SR_WRITE
		&& fr.bits == `EWP_SR_WRITE_BITS && latch_r && !hw_prot
		|=> state_r == ewp_st_busy && pend_r == {$past(fr.data[`EWP_SR_PPE]),
		$past(fr.data[`EWP_SR_BG_HI]), $past(fr.data[`EWP_SR_BG_LO])})
		else $error("Allowed status write was not started.");

	pin_release_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_SR_WRITE
		&& fr.bits == `EWP_SR_WRITE_BITS && latch_r && (pr_s_r || !ppe_r)
		|=> state_r == ewp_st_busy)
		else $error("Status write refused without hardware protection.");

	array_accept_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_ARRAY_WRITE && array_ok
		&& latch_r && !guarded(bg_r, fr.addr) |=> kind_r == ewp_wk_array)
		else $error("Allowed array write was not started.");

	guard_map_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_idle && frame_end && fr.opcode == `EWP_OP_ARRAY_WRITE
		&& ((&bg_r)
		|| (bg_r == `EWP_GUARD_HALF && fr.addr >= `EWP_HALF_BASE)
		|| (bg_r == `EWP_GUARD_QUARTER && fr.addr >= `EWP_QUARTER_BASE))
		|=> state_r == ewp_st_idle)
		else $error("Write accepted inside a guarded range.");

	nv_apply_a : assert property (@(posedge clock) disable iff (rst)
		$fell(state_r == ewp_st_busy) && $past(kind_r) == ewp_wk_status |-> {ppe_r, bg_r} == $past(pend_r))
		else $error("Status write did not apply its bits.");

	busy_hold_a : assert property (@(posedge clock) disable iff (rst)
		state_r == ewp_st_busy && timer_r != TW'(WRITE_CYCLES - 1)
		|=> state_r == ewp_st_busy && $stable(kind_r) && $stable(pend_r))
		else $error("Running write cycle was disturbed.");

	busy_kind_a : assert property (@(posedge clock) disable iff (rst)
		write_busy |-> kind_r != ewp_wk_none)
		else $error("Busy shown with no write under way.");

endmodule : ewp_protect_top

/* File: verification/ewp_host_model.sv */
// Purpose: Host serial master that frames commands for the protection block.
// Assumes: Mode 0 link, clock idles low, 64 ns link period.
// Notes: The link clock runs only inside frames, as a real host does.
`timescale 1ns/100ps
module ewp_host_model (
	input  wire logic clock,
	input  wire logic so_line,
	input  wire logic so_oe_n,
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	output logic      oe_seen
);
	// Driven after time zero so the device sees chip select rise and releases its output.
	initial begin
		cs_n    <= 1'b1;
		sck     <= 1'b0;
		si      <= 1'b0;
		oe_seen <= 1'b0;
	end

	// A bit count other than the frame length is how a refused frame is made.
	task automatic xfer(input logic [7:0] op, input logic [23:0] dat, input int nbits,
		output logic [7:0] rd);
		logic [31:0] word;
		word = {op, dat};
		rd = 8'h00;
		oe_seen = 1'b0;
		@(posedge clock);
		cs_n <= 1'b0;
		#20;
		for (int i = 0; i < nbits; i++) begin
			si = word[31 - i];
			#32;
			if (so_oe_n === 1'b0) oe_seen = 1'b1;
			sck = 1'b1;
			if (i >= 8) rd = {rd[6:0], so_line};
			#32;
			sck = 1'b0;
		end
		// The data line is left changed so no stale bit can be mistaken for data.
		si = ~si;
		#32;
		cs_n = 1'b1;
		repeat (6) @(posedge clock);
	endtask : xfer
endmodule : ewp_host_model

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench of the write-protect and status block.
// Assumes: Host model frames every command; the write cycle is shortened.
// Notes: Expected values are built from the command codes and guard bounds.
`timescale 1ns/100ps
module tb_top;
	import ewp_pkg::*;
	localparam int         WC    = 400;
	localparam logic [7:0] L_SET = 8'h06;
	localparam logic [7:0] L_CLR = 8'h04;
	localparam logic [7:0] S_RD  = 8'h05;
	localparam logic [7:0] S_WR  = 8'h01;
	localparam logic [7:0] A_WR  = 8'h02;
	logic        clock, rst, protect_n, sck, cs_n, si, so, so_oe_n;
	logic        write_busy, so_line, oe_seen, ok;
	logic [7:0]  status_q, rd;
	logic [11:0] a;
	logic [11:0] addrs [6];
	int          n_fail, comparisons;

	ewp_protect_top #(.WRITE_CYCLES(WC)) dut (.clock(clock), .rst(rst), .sck(sck),
		.cs_n(cs_n), .si(si), .protect_n(protect_n), .so(so), .so_oe_n(so_oe_n),
		.status_q(status_q), .write_busy(write_busy));
	// A released output is shown inverted, never as a plausible bit.
	assign so_line = so_oe_n ? ~so : so;
	ewp_host_model host (.clock(clock), .so_line(so_line), .so_oe_n(so_oe_n),
		.sck(sck), .cs_n(cs_n), .si(si), .oe_seen(oe_seen));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report

	task automatic cmd(input logic [7:0] op, input logic [23:0] d, input int n);
		host.xfer(op, d, n, rd);
	endtask : cmd

	task automatic sr_write(input logic [7:0] d);
		cmd(S_WR, {d, 16'h0000}, 16);
	endtask : sr_write

	task automatic aw(input logic [11:0] ad);
		cmd(A_WR, {4'h0, ad, 8'h5a}, 32);
	endtask : aw

	task automatic wait_idle;
		int k;
		k = 0;
		while (write_busy !== 1'b0 && k < 1000) begin
			@(posedge clock);
			k++;
		end
		check("busy ends", write_busy, 1'b0);
		repeat (2) @(posedge clock);
	endtask : wait_idle

	initial begin
		#2000000;
		n_fail++;
		final_report();
	end

	initial begin
		n_fail = 0;
		comparisons = 0;
		addrs = '{12'h000, 12'h7ff, 12'h800, 12'hbff, 12'hc00, 12'hfff};
		rst <= 1'b1;
		protect_n <= 1'b1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		check("status reset", status_q, 8'h00);
		check("so released", so_oe_n, 1'b1);
		$display("test power_up done");
		sr_write(8'h8c);
		check("busy no latch", write_busy, 1'b0);
		cmd(L_SET, 24'h0, 9);
		check("set 9 bits", status_q, 8'h00);
		cmd(L_SET, 24'h0, 8);
		check("set latch", status_q, 8'h02);
		cmd(L_CLR, 24'h0, 7);
		check("clear 7 bits", status_q, 8'h02);
		cmd(L_CLR, 24'h0, 8);
		check("clear latch", status_q, 8'h00);
		cmd(L_SET, 24'h0, 8);
		cmd(S_WR, {8'h8c, 16'h0000}, 15);
		check("short status write", write_busy, 1'b0);
		$display("test latch done");
		sr_write(8'hff);
		check("status write busy", write_busy, 1'b1);
		check("so quiet in write", oe_seen, 1'b0);
		cmd(S_RD, 24'h0, 16);
		check("read while busy", rd, 8'h03);
		check("so driven in read", oe_seen, 1'b1);
		check("so released after", so_oe_n, 1'b1);
		aw(12'h000);
		cmd(L_SET, 24'h0, 8);
		wait_idle();
		check("status applied", status_q, 8'h8c);
		check("no second cycle", write_busy, 1'b0);
		$display("test status_write done");
		protect_n <= 1'b0;
		cmd(L_SET, 24'h0, 8);
		sr_write(8'h00);
		check("hw protect", write_busy, 1'b0);
		check("hw latch kept", status_q, 8'h8e);
		aw(12'h000);
		check("all guarded", write_busy, 1'b0);
		protect_n <= 1'b1;
		repeat (4) @(posedge clock);
		sr_write(8'h80);
		check("pin high allows", write_busy, 1'b1);
		protect_n <= 1'b0;
		wait_idle();
		check("pin fall mid write", status_q, 8'h80);
		cmd(L_SET, 24'h0, 8);
		aw(12'h000);
		check("array under hw", write_busy, 1'b1);
		wait_idle();
		check("latch after array", status_q, 8'h80);
		protect_n <= 1'b1;
		$display("test hw_protect done");
		for (int g = 0; g < 4; g++) begin
			cmd(L_SET, 24'h0, 8);
			sr_write({4'h0, g[1:0], 2'b00});
			wait_idle();
			check("guards set", status_q, {4'h0, g[1:0], 2'b00});
			protect_n <= 1'b0;
			for (int j = 0; j < 6; j++) begin
				a = addrs[j];
				ok = (g == 0) || (g == 1 && a < 12'hc00) || (g == 2 && a < 12'h800);
				cmd(L_SET, 24'h0, 8);
				aw(a);
				check("array busy", write_busy, ok);
				wait_idle();
				check("latch after", status_q[1], !ok);
			end
		end
		$display("test guards done");
		final_report();
	end
endmodule : tb_top
